/* File: rsm_pkg.sv */
// Shared constants and types of the received-signal-strength monitor.
// Assumes one hclk domain; the modem bit clock is sampled, not used as a clock.
package rsm_pkg;
   // Register byte offsets
   localparam logic [7:0] A_CONFIG = 8'h00;
   localparam logic [7:0] A_THRESH = 8'h04;
   localparam logic [7:0] A_OFFSET = 8'h08;
   localparam logic [7:0] A_FR_SEL = 8'h0C;
   localparam logic [7:0] A_FAST = 8'h10;
   localparam logic [7:0] A_QUERY = 8'h14;
   localparam logic [7:0] A_QREPLY = 8'h18;
   localparam logic [7:0] A_INT_ST = 8'h1C;
   localparam logic [7:0] A_INT_MASK = 8'h20;
   localparam logic [7:0] A_LIVE = 8'h24;
   localparam logic [7:0] A_GPIO_SEL = 8'h28;
   // Config fields and reset values
   localparam int CFG_AVG = 2;
   localparam int CFG_HOP = 3;
   localparam int CFG_CNT_LSB = 8;
   localparam logic [15:0] CFG_RST = 16'h0400;
   localparam logic [7:0] THRESH_RST = 8'hFF;
   localparam logic [7:0] OFFSET_RST = 8'h40;
   localparam logic [7:0] MIN_BITS_PLAIN = 8'h04;
   localparam logic [7:0] MIN_BITS_AVG = 8'h07;
   localparam int AVG_DEPTH = 4;
   localparam logic [1:0] PHASE_LAST = 2'h3;
   // Interrupt status bits
   localparam int IRQ_W = 3;
   localparam int IRQ_ABOVE = 0;
   localparam int IRQ_CAPT = 1;
   localparam int IRQ_QRY = 2;
   // Synchroniser bundle layout
   localparam int SY_W = 12;
   localparam int SY_CLK = 11;
   localparam int SY_RX = 10;
   localparam int SY_PRE = 9;
   localparam int SY_SYN = 8;
   // Status query delay
   localparam int QUERY_DELAY_US = 33;
   localparam int CLK_MHZ = 250;
   localparam int QUERY_CYCLES_DFLT = QUERY_DELAY_US * CLK_MHZ;
   typedef enum logic [1:0] {CAP_PREAMBLE = 2'h0, CAP_SYNC = 2'h1, CAP_BITS = 2'h2} rsm_cap_t;
   typedef enum logic [1:0] {FR_NONE = 2'h0, FR_HELD = 2'h1, FR_CUR = 2'h2, FR_FLAGS = 2'h3} rsm_fr_t;
   typedef enum logic [1:0] {QRY_IDLE = 2'b01, QRY_BUSY = 2'b10} rsm_qry_t;
endpackage

/* File: rsm_avg_if.sv */
// Carries per-bit samples to the averager and the current value back.
// Assumes both ends run on hclk.
`timescale 1ns/1ps
`default_nettype none
interface rsm_avg_if;
   logic [7:0] sample;
   logic sample_vld;
   logic avg_en;
   logic clear;
   logic [7:0] value;
   logic value_vld;
   modport src (output sample, sample_vld, avg_en, clear, input value, value_vld);
   modport avg (input sample, sample_vld, avg_en, clear, output value, value_vld);
endinterface
`default_nettype wire

/* File: rsm_sync.sv */
// Two-flop synchroniser for a bundle of pin levels.
// Assumes each bit is a level that is stable for several hclk cycles.
`timescale 1ns/1ps
`default_nettype none
module rsm_sync #(parameter int W = 1) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         q <= '0;
      end else begin
         s1_q <= d;
         q <= s1_q;
      end
   end
endmodule
`default_nettype wire

/* File: rsm_avg.sv */
// Per-bit or four-bit-mean current strength value.
// Assumes one sample_vld pulse per bit period, on hclk.
`timescale 1ns/1ps
`default_nettype none
module rsm_avg import rsm_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   rsm_avg_if.avg bus
);
   logic [7:0] win_q [AVG_DEPTH-1];
   logic [1:0] phase_q;
   logic [9:0] sum_w;
   always_comb begin
      sum_w = {2'h0, bus.sample} + {2'h0, win_q[0]} + {2'h0, win_q[1]} + {2'h0, win_q[2]};
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < AVG_DEPTH - 1; i++) win_q[i] <= 8'h00;
         phase_q <= 2'h0;
         bus.value <= 8'h00;
         bus.value_vld <= 1'b0;
      end else if (bus.clear) begin
         for (int i = 0; i < AVG_DEPTH - 1; i++) win_q[i] <= 8'h00;
         phase_q <= 2'h0;
         bus.value <= 8'h00;
         bus.value_vld <= 1'b0;
      end else begin
         bus.value_vld <= 1'b0;
         if (bus.sample_vld) begin
            win_q[0] <= bus.sample;
            win_q[1] <= win_q[0];
            win_q[2] <= win_q[1];
            phase_q <= phase_q + 2'h1;
            if (!bus.avg_en) begin
               bus.value <= bus.sample;
               bus.value_vld <= 1'b1;
            end else if (phase_q == PHASE_LAST) begin
               bus.value <= sum_w[9:2];
               bus.value_vld <= 1'b1;
            end
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_avg_rate;
      bus.avg_en && bus.sample_vld && !bus.clear && phase_q != PHASE_LAST |=> !bus.value_vld;
   endproperty
   a_avg_rate: assert property (p_avg_rate) else $error("averaged value refreshed early");
   property p_avg_mean;
      bus.avg_en && bus.sample_vld && !bus.clear && phase_q == PHASE_LAST
         |=> bus.value == $past(sum_w[9:2]);
   endproperty
   a_avg_mean: assert property (p_avg_mean) else $error("averaged value wrong");
endmodule
`default_nettype wire

/* File: rsm_top.sv */
// Received-signal-strength monitor: AHB-Lite registers, capture, threshold, query.
// Assumes modem pins change on the bit clock falling edge and stay stable around its rise.
`timescale 1ns/1ps
`default_nettype none
module rsm_top import rsm_pkg::*; #(
   parameter int QRY_CYCLES = QUERY_CYCLES_DFLT
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Modem side, bit clock domain
   input wire logic bit_clk,
   input wire logic rx_active,
   input wire logic preamble_det,
   input wire logic sync_det,
   input wire logic [7:0] chan_power,
   // Notification
   output logic irq,
   output logic [3:0] gpio,
   output logic hop_stay,
   output logic hop_next
);
   logic [SY_W-1:0] sy_w;
   logic bclk_d_q, rx_d_q, pre_d_q, syn_d_q;
   logic bit_edge, rx_rise, pre_rise, syn_rise, rx_s;
   logic dp_q, wr_q, hready_q;
   logic [7:0] addr_q;
   logic [31:0] hrdata_q, rd_w, fast_w;
   logic wr_en;
   logic [15:0] cfg_q;
   logic [7:0] thr_q, off_q, fr_sel_q, gpio_sel_q, raw_q, held_q, bit_cnt_q, min_bits, tgt_bits;
   logic [7:0] qry_cur_q, qry_held_q;
   logic held_vld_q, evt_q, live_q, above_held_q, hop_stay_q, hop_next_q, irq_q;
   logic [IRQ_W-1:0] st_q, mask_q, st_set;
   logic [3:0] gpio_q;
   logic capture, evt_now, qry_start;
   logic [15:0] qcnt_q;
   rsm_qry_t qst_q;
   rsm_avg_if avg_if ();

   // Synchronise every modem pin before use
   rsm_sync #(.W(SY_W)) u_sync (
      .clk(hclk),
      .rst_n(hresetn),
      .d({bit_clk, rx_active, preamble_det, sync_det, chan_power}),
      .q(sy_w)
   );

   rsm_avg u_avg (
      .clk(hclk),
      .rst_n(hresetn),
      .bus(avg_if)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bclk_d_q <= 1'b0;
         rx_d_q <= 1'b0;
         pre_d_q <= 1'b0;
         syn_d_q <= 1'b0;
      end else begin
         bclk_d_q <= sy_w[SY_CLK];
         rx_d_q <= sy_w[SY_RX];
         pre_d_q <= sy_w[SY_PRE];
         syn_d_q <= sy_w[SY_SYN];
      end
   end
   assign rx_s = sy_w[SY_RX];
   assign bit_edge = sy_w[SY_CLK] & ~bclk_d_q;
   assign rx_rise = rx_s & ~rx_d_q;
   assign pre_rise = sy_w[SY_PRE] & ~pre_d_q;
   assign syn_rise = sy_w[SY_SYN] & ~syn_d_q;

   // Post-filter power feeds the averager unscaled, half-dB steps
   assign avg_if.sample = sy_w[7:0];
   assign avg_if.sample_vld = bit_edge & rx_s;
   assign avg_if.avg_en = cfg_q[CFG_AVG];
   assign avg_if.clear = rx_rise;

   // AHB-Lite: one wait state so read data leaves a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_q <= 1'b0;
         wr_q <= 1'b0;
         addr_q <= 8'h00;
         hready_q <= 1'b1;
         hrdata_q <= 32'h0000_0000;
      end else if (dp_q) begin
         dp_q <= 1'b0;
         hready_q <= 1'b1;
         hrdata_q <= wr_q ? 32'h0000_0000 : rd_w;
      end else if (hsel && htrans[1] && hready) begin
         dp_q <= 1'b1;
         wr_q <= hwrite;
         addr_q <= haddr[7:0];
         hready_q <= 1'b0;
      end
   end
   assign wr_en = dp_q & wr_q;
   assign hrdata = hrdata_q;
   assign hreadyout = hready_q;
   assign hresp = 1'b0;

   function automatic logic [7:0] slot_val(input logic [1:0] s);
      case (s)
         FR_HELD: slot_val = held_q;
         FR_CUR: slot_val = avg_if.value;
         FR_FLAGS: slot_val = {5'h00, held_vld_q, above_held_q, live_q};
         default: slot_val = 8'h00;
      endcase
   endfunction

   function automatic logic gpio_val(input logic [1:0] s);
      case (s)
         2'h1: gpio_val = above_held_q;
         2'h2: gpio_val = live_q;
         2'h3: gpio_val = hop_stay_q;
         default: gpio_val = 1'b0;
      endcase
   endfunction

   always_comb begin
      for (int i = 0; i < 4; i++) fast_w[8*i +: 8] = slot_val(fr_sel_q[2*i +: 2]);
   end

   always_comb begin
      case (addr_q)
         A_CONFIG: rd_w = {16'h0000, cfg_q};
         A_THRESH: rd_w = {24'h000000, thr_q};
         A_OFFSET: rd_w = {24'h000000, off_q};
         A_FR_SEL: rd_w = {24'h000000, fr_sel_q};
         A_FAST: rd_w = fast_w;
         A_QUERY: rd_w = {31'h00000000, qst_q == QRY_IDLE};
         A_QREPLY: rd_w = {16'h0000, qry_held_q, qry_cur_q};
         A_INT_ST: rd_w = {{(32-IRQ_W){1'b0}}, st_q};
         A_INT_MASK: rd_w = {{(32-IRQ_W){1'b0}}, mask_q};
         A_LIVE: rd_w = {14'h0000, held_vld_q, live_q, held_q, avg_if.value};
         A_GPIO_SEL: rd_w = {24'h000000, gpio_sel_q};
         default: rd_w = 32'h0000_0000;
      endcase
   end

   // Software-written configuration
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q <= CFG_RST;
         thr_q <= THRESH_RST;
         off_q <= OFFSET_RST;
         fr_sel_q <= 8'h00;
         mask_q <= '0;
         gpio_sel_q <= 8'h00;
      end else if (wr_en) begin
         case (addr_q)
            A_CONFIG: cfg_q <= hwdata[15:0];
            A_THRESH: thr_q <= hwdata[7:0];
            A_OFFSET: off_q <= hwdata[7:0];
            A_FR_SEL: fr_sel_q <= hwdata[7:0];
            A_INT_MASK: mask_q <= hwdata[IRQ_W-1:0];
            A_GPIO_SEL: gpio_sel_q <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // Capture point: never before the settling or averaging minimum
   assign min_bits = cfg_q[CFG_AVG] ? MIN_BITS_AVG : MIN_BITS_PLAIN;
   assign tgt_bits = (cfg_q[CFG_CNT_LSB +: 8] < min_bits) ? min_bits : cfg_q[CFG_CNT_LSB +: 8];
   always_comb begin
      case (rsm_cap_t'(cfg_q[1:0]))
         CAP_PREAMBLE: evt_now = pre_rise;
         CAP_SYNC: evt_now = syn_rise;
         default: evt_now = bit_cnt_q >= tgt_bits;
      endcase
   end
   assign capture = rx_s & ~rx_rise & ~held_vld_q & (evt_q | evt_now) & (bit_cnt_q >= min_bits);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bit_cnt_q <= 8'h00;
      end else if (rx_rise) begin
         bit_cnt_q <= 8'h00;
      end else if (bit_edge && rx_s && bit_cnt_q != 8'hFF) begin
         bit_cnt_q <= bit_cnt_q + 8'h01;
      end
   end

   // Early event waits until the minimum count is reached
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         evt_q <= 1'b0;
      end else if (rx_rise || capture) begin
         evt_q <= 1'b0;
      end else if (rx_s && evt_now) begin
         evt_q <= 1'b1;
      end
   end

   // Held value: cleared on entry, kept after the packet
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         held_q <= 8'h00;
         held_vld_q <= 1'b0;
      end else if (rx_rise) begin
         held_q <= 8'h00;
         held_vld_q <= 1'b0;
      end else if (capture) begin
         held_q <= avg_if.value;
         held_vld_q <= 1'b1;
      end
   end

   // Threshold: live compare each cycle, held version sticky per packet
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         live_q <= 1'b0;
         above_held_q <= 1'b0;
      end else begin
         live_q <= avg_if.value > thr_q;
         // Fresh compare: live_q lags entry a cycle and would carry the last packet over
         if (rx_rise) begin
            above_held_q <= 1'b0;
         end else if (avg_if.value > thr_q) begin
            above_held_q <= 1'b1;
         end
      end
   end

   // Hopping decision uses the raw per-bit sample, never the average
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         raw_q <= 8'h00;
         hop_stay_q <= 1'b0;
         hop_next_q <= 1'b0;
      end else begin
         if (rx_rise) begin
            raw_q <= 8'h00;
         end else if (avg_if.sample_vld) begin
            raw_q <= avg_if.sample;
         end
         hop_stay_q <= cfg_q[CFG_HOP] & rx_s & (raw_q > thr_q);
         hop_next_q <= cfg_q[CFG_HOP] & rx_s & ~(raw_q > thr_q);
      end
   end

   // Status query: snapshot now, ready after the fixed delay
   assign qry_start = wr_en & (addr_q == A_QUERY) & hwdata[0] & (qst_q == QRY_IDLE);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         qst_q <= QRY_IDLE;
         qcnt_q <= 16'h0000;
         qry_cur_q <= 8'h00;
         qry_held_q <= 8'h00;
      end else begin
         case (qst_q)
            QRY_IDLE: begin
               if (qry_start) begin
                  qst_q <= QRY_BUSY;
                  qcnt_q <= 16'(QRY_CYCLES - 1);
                  qry_cur_q <= avg_if.value;
                  qry_held_q <= held_q;
               end
            end
            QRY_BUSY: begin
               if (qcnt_q == 16'h0001) begin
                  qst_q <= QRY_IDLE;
               end
               qcnt_q <= qcnt_q - 16'h0001;
            end
            default: qst_q <= QRY_IDLE;
         endcase
      end
   end

   // Sticky status, write one to clear; a new event beats the clear
   always_comb begin
      st_set = '0;
      st_set[IRQ_ABOVE] = avg_if.value > thr_q && !live_q;
      st_set[IRQ_CAPT] = capture;
      st_set[IRQ_QRY] = qst_q == QRY_BUSY && qcnt_q == 16'h0001;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= '0;
      end else if (wr_en && addr_q == A_INT_ST) begin
         st_q <= (st_q & ~hwdata[IRQ_W-1:0]) | st_set;
      end else begin
         st_q <= st_q | st_set;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_q <= 1'b0;
         gpio_q <= 4'h0;
      end else begin
         irq_q <= |(st_q & mask_q);
         for (int i = 0; i < 4; i++) gpio_q[i] <= gpio_val(gpio_sel_q[2*i +: 2]);
      end
   end
   assign irq = irq_q;
   assign gpio = gpio_q;
   assign hop_stay = hop_stay_q;
   assign hop_next = hop_next_q;

   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   int qwait_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) qwait_q <= 0;
      else if (qry_start) qwait_q <= 1;
      else if (qst_q == QRY_BUSY) qwait_q <= qwait_q + 1;
   end
   property p_cap_min;
      $rose(held_vld_q) |-> $past(bit_cnt_q) >= $past(min_bits) && $past(rx_s);
   endproperty
   a_cap_min: assert property (p_cap_min) else $error("held value captured too early");
   property p_bits_target;
      $rose(held_vld_q) && $past(cfg_q[1:0]) == CAP_BITS |-> $past(bit_cnt_q) >= $past(tgt_bits);
   endproperty
   a_bits_target: assert property (p_bits_target) else $error("bit count capture before target");
   property p_clear_entry;
      rx_rise |=> held_q == 8'h00 && !held_vld_q;
   endproperty
   a_clear_entry: assert property (p_clear_entry) else $error("held value not cleared on entry");
   property p_zero_uncapt;
      !held_vld_q |-> held_q == 8'h00;
   endproperty
   a_zero_uncapt: assert property (p_zero_uncapt) else $error("uncaptured held value not zero");
   property p_once;
      held_vld_q && !rx_rise |=> $stable(held_q) && held_vld_q;
   endproperty
   a_once: assert property (p_once) else $error("held value changed within packet");
   property p_qry_delay;
      $fell(qst_q == QRY_BUSY) |-> qwait_q == QRY_CYCLES;
   endproperty
   a_qry_delay: assert property (p_qry_delay) else $error("query ready at wrong time");
   property p_qry_snap;
      qry_start |=> qry_cur_q == $past(avg_if.value) && qry_held_q == $past(held_q) && qst_q == QRY_BUSY;
   endproperty
   a_qry_snap: assert property (p_qry_snap) else $error("query snapshot wrong");
   property p_thr_irq;
      $rose(live_q) && !wr_en |-> st_q[IRQ_ABOVE] ##1 (irq_q || !mask_q[IRQ_ABOVE]);
   endproperty
   a_thr_irq: assert property (p_thr_irq) else $error("threshold event not flagged");
   property p_hop;
      cfg_q[CFG_HOP] && rx_s && raw_q > thr_q |=> hop_stay_q && !hop_next_q;
   endproperty
   a_hop: assert property (p_hop) else $error("hop decision wrong");
   property p_fast_answer;
      hsel && htrans[1] && hready && !dp_q |=> !hreadyout ##1 hreadyout;
   endproperty
   a_fast_answer: assert property (p_fast_answer) else $error("bus answer timing wrong");
   c_capture: cover property ($rose(held_vld_q));
   c_query: cover property ($fell(qst_q == QRY_BUSY));
   c_irq: cover property ($rose(irq_q));
endmodule
`default_nettype wire

/* File: rsm_modem_model.sv */
// Modem-side model: bit clock, receive level, detector levels, power codes.
// Assumes the bench calls frame() from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module rsm_modem_model (
   // Modem pins
   output logic bit_clk,
   output logic rx_active,
   output logic preamble_det,
   output logic sync_det,
   output logic [7:0] chan_power
);
   initial begin
      bit_clk = 1'b0;
      rx_active = 1'b0;
      preamble_det = 1'b0;
      sync_det = 1'b0;
      chan_power = 8'h00;
   end
   // Power p before bit c, q from it; ev 1 preamble, 2 sync, at bit eb
   task automatic frame(input logic [7:0] p, q, input int c, n, ev, eb);
      #3.3 rx_active = 1'b1;
      // Receive entry leads every event by at least half a bit
      #80;
      for (int i = 1; i <= n; i++) begin
         chan_power = (i < c) ? p : q;
         if (i == eb) begin
            preamble_det = (ev == 1);
            sync_det = (ev == 2);
         end
         #80 bit_clk = 1'b1;
         #80 bit_clk = 1'b0;
      end
      #80 rx_active = 1'b0;
      preamble_det = 1'b0;
      sync_det = 1'b0;
      // Released bus shows the inverse, never a stale value
      chan_power = ~chan_power;
   endtask
endmodule
`default_nettype wire

/* File: rx_signal_strength_monitor_tb_top.sv */
// Self-checking bench: AHB-Lite master tasks, one task per scenario.
// Assumes the modem model drives the pins; one wait state per transfer.
`timescale 1ns/1ps
`default_nettype none
module rx_signal_strength_monitor_tb_top import rsm_pkg::*;;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hrdata, r;
   logic hreadyout, hresp, irq, hop_stay, hop_next;
   logic bit_clk, rx_active, preamble_det, sync_det;
   logic [3:0] gpio;
   logic [7:0] chan_power;
   int n_mismatch = 0;
   int total_checks = 0;
   always #2 hclk = ~hclk;
   rsm_top #(.QRY_CYCLES(20)) i_rsm_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .bit_clk(bit_clk), .rx_active(rx_active), .preamble_det(preamble_det),
      .sync_det(sync_det), .chan_power(chan_power), .irq(irq), .gpio(gpio), .hop_stay(hop_stay),
      .hop_next(hop_next)
   );
   rsm_modem_model i_rsm_modem_model (
      .bit_clk(bit_clk), .rx_active(rx_active), .preamble_det(preamble_det), .sync_det(sync_det),
      .chan_power(chan_power)
   );
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk(r, e);
   endtask
   // Irq follows its cause one cycle late
   task automatic irq_is(input logic e);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, {31'h0, e});
   endtask
   task automatic fr(input logic [7:0] p, q, input int c, n, ev, eb);
      i_rsm_modem_model.frame(p, q, c, n, ev, eb);
      repeat (10) @(posedge hclk);
   endtask
   task automatic t_reset;
      chk({31'h0, hresp}, 32'h0);
      rd(A_CONFIG, 32'h400);
      rd(A_THRESH, 32'hFF);
      rd(A_OFFSET, 32'h40);
      rd(A_INT_MASK, 32'h0);
      rd(A_LIVE, 32'h0);
      ahb(1'b1, 8'h3C, 32'hFFFFFFFF);
      rd(8'h3C, 32'h0);
      ahb(1'b1, A_FAST, 32'hFFFFFFFF);
      rd(A_FAST, 32'h0);
      ahb(1'b1, A_OFFSET, 32'h40);
      irq_is(1'b0);
   endtask
   task automatic t_once;
      ahb(1'b1, A_CONFIG, 32'h402);
      fr(8'h11, 8'h22, 7, 10, 0, 0);
      rd(A_LIVE, 32'h21122);
      // Host view of the current code: half of it, less offset 0x40, less 70
      chk(32'(r[7:0] / 2) - 32'd134, 32'hFFFF_FF8B);
   endtask
   task automatic t_min;
      ahb(1'b1, A_CONFIG, 32'h202);
      fr(8'h33, 8'h33, 9, 3, 0, 0);
      rd(A_LIVE, 32'h33);
      fr(8'h33, 8'h33, 9, 4, 0, 0);
      rd(A_LIVE, 32'h23333);
   endtask
   task automatic t_avg;
      ahb(1'b1, A_CONFIG, 32'h404);
      fr(8'h20, 8'h60, 4, 4, 1, 1);
      rd(A_LIVE, 32'h30);
      fr(8'h50, 8'h50, 9, 8, 1, 1);
      rd(A_LIVE, 32'h25050);
      ahb(1'b1, A_CONFIG, 32'h401);
      fr(8'h20, 8'h60, 4, 6, 2, 5);
      rd(A_LIVE, 32'h26060);
   endtask
   task automatic t_thr;
      ahb(1'b1, A_THRESH, 32'h70);
      ahb(1'b1, A_INT_ST, 32'h7);
      ahb(1'b1, A_INT_MASK, 32'h1);
      ahb(1'b1, A_GPIO_SEL, 32'h9);
      fr(8'h70, 8'h70, 9, 5, 0, 0);
      rd(A_INT_ST, 32'h0);
      chk({28'h0, gpio}, 32'h0);
      fr(8'h71, 8'h71, 9, 5, 0, 0);
      rd(A_INT_ST, 32'h1);
      chk({28'h0, gpio}, 32'h3);
      irq_is(1'b1);
      ahb(1'b1, A_INT_MASK, 32'h0);
      irq_is(1'b0);
      ahb(1'b1, A_INT_MASK, 32'h1);
      irq_is(1'b1);
      ahb(1'b1, A_INT_ST, 32'h1);
      irq_is(1'b0);
      rd(A_INT_ST, 32'h0);
   endtask
   task automatic t_fast;
      ahb(1'b1, A_FR_SEL, 32'hC9);
      rd(A_FAST, 32'h03007100);
   endtask
   task automatic t_qry;
      ahb(1'b1, A_INT_MASK, 32'h4);
      ahb(1'b1, A_QUERY, 32'h1);
      rd(A_QUERY, 32'h0);
      repeat (25) @(posedge hclk);
      rd(A_QUERY, 32'h1);
      rd(A_INT_ST, 32'h4);
      irq_is(1'b1);
      rd(A_QREPLY, 32'h71);
   endtask
   // Raw samples cross the threshold while the four-bit mean stays below it
   task automatic t_hop;
      ahb(1'b1, A_CONFIG, 32'h40C);
      ahb(1'b1, A_GPIO_SEL, 32'hC9);
      fork
         fr(8'h10, 8'h90, 3, 4, 0, 0);
         begin
            repeat (100) @(posedge hclk);
            chk({30'h0, hop_stay, hop_next}, 32'h1);
            repeat (80) @(posedge hclk);
            chk({30'h0, hop_stay, hop_next}, 32'h2);
            chk({28'h0, gpio}, 32'h8);
         end
      join
      chk({30'h0, hop_stay, hop_next}, 32'h0);
      rd(A_LIVE, 32'h50);
   endtask
   task automatic wrap_up;
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_once;
      t_min;
      t_avg;
      t_thr;
      t_fast;
      t_qry;
      t_hop;
      wrap_up;
   end
   // Whole run needs about 10 us
   initial begin
      #300000;
      n_mismatch++;
      wrap_up;
   end
endmodule
`default_nettype wire
